// ===== lane_62b64b_frame_encoder.sv
// Per-lane 62b/64b transmit frame encoder with output skid buffer
`timescale 1ns/1ps
`default_nettype none
module lane_62b64b_frame_encoder
	import lane_enc_pkg::*;
#(
	parameter logic [LFSR_W-1:0] LFSR_SEED     = LFSR_SEED_DEF,
	parameter logic [63:0]       ALIGN_WORD    = ALIGN_PATTERN,
	parameter int                ALIGN_COUNT   = ALIGN_FRAMES,
	parameter int                SEED_COUNT    = SEED_FRAMES
) (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_clk_en,
	input  wire logic                 i_sync,
	input  wire logic                 i_toggle_hold,
	input  wire logic [PAYLOAD_W-1:0] i_data,
	input  wire logic                 i_data_valid,
	output logic                      o_data_ready,
	output logic [FRAME_W-1:0]        o_frame,
	output logic                      o_frame_valid,
	input  wire logic                 i_frame_ready,
	output logic                      o_pattern_phase,
	output logic                      o_seed_phase
);
	// ************************************************************
	// Input synchronisers (sync and option come from pins)
	// ************************************************************
	logic       sync_m_r, sync_s_r, sync_d_r;
	logic       hold_m_r, hold_s_r;
	wire        sync_pulse = sync_s_r & ~sync_d_r;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_m_r <= 1'b0;
			sync_s_r <= 1'b0;
			sync_d_r <= 1'b0;
			hold_m_r <= 1'b0;
			hold_s_r <= 1'b0;
		end else if (i_clk_en) begin
			sync_m_r <= i_sync;
			sync_s_r <= sync_m_r;
			sync_d_r <= sync_s_r;
			hold_m_r <= i_toggle_hold;
			hold_s_r <= hold_m_r;
		end
	end

	// ************************************************************
	// Scrambler sequence
	// ************************************************************
	function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] s);
		logic [LFSR_W-1:0] n;
		n = '0;
		for (int i = LFSR_TAP_LO; i < LFSR_W; i++) begin
			n[i] = s[i] ^ s[i-LFSR_TAP_LO];
		end
		for (int i = 0; i < LFSR_TAP_LO; i++) begin
			n[i] = s[i] ^ s[i+LFSR_W-2*LFSR_TAP_LO] ^ s[i+LFSR_W-LFSR_TAP_LO];
		end
		return n;
	endfunction

	// Ones minus zeros of a 64-bit word
	function automatic logic signed [DISP_W-1:0] word_disp(input logic [FRAME_W-1:0] w);
		logic signed [DISP_W-1:0] d;
		d = '0;
		for (int i = 0; i < FRAME_W; i++) begin
			d = w[i] ? d + DISP_W'(1) : d - DISP_W'(1);
		end
		return d;
	endfunction

	logic [LFSR_W-1:0]        lfsr_r;
	wire  [LFSR_W-1:0]        lfsr_a = lfsr_step(lfsr_r);
	wire  [LFSR_W-1:0]        lfsr_b = lfsr_step(lfsr_a);
	wire  [PAYLOAD_W-1:0]     seq_word = {lfsr_b, lfsr_a};

	// ************************************************************
	// Phase control
	// ************************************************************
	phase_e               phase_r;
	logic [CNT_W-1:0]     cnt_r;
	logic                 toggle_r;
	logic signed [DISP_W-1:0] disp_r;
	logic                 buf_ready;

	wire  in_idle   = (phase_r == ST_IDLE);
	wire  in_pat    = (phase_r == ST_PATTERN);
	wire  in_seed   = (phase_r == ST_SEED);
	wire  fire      = buf_ready & (in_idle ? i_data_valid : 1'b1);
	wire  cnt_last  = in_pat ? (cnt_r == CNT_W'(ALIGN_COUNT - 1))
	                         : (cnt_r == CNT_W'(SEED_COUNT - 1));
	// Pattern frames leave toggle, sequence and disparity untouched
	wire  lane_step = fire & ~in_pat;

	// ************************************************************
	// Phase sequencer
	// ************************************************************
	phase_e               phase_nxt;

	// Sync outranks everything, so a pulse mid-sequence restarts it
	always_comb begin
		phase_nxt = phase_r;
		unique case (phase_r)
			ST_IDLE: begin
				phase_nxt = ST_IDLE;
			end
			ST_PATTERN: begin
				if (fire && cnt_last) begin
					phase_nxt = ST_SEED;
				end
			end
			ST_SEED: begin
				if (fire && cnt_last) begin
					phase_nxt = ST_IDLE;
				end
			end
			default: begin
				phase_nxt = ST_IDLE;
			end
		endcase
		if (sync_pulse) begin
			phase_nxt = ST_PATTERN;
		end
	end

	// ************************************************************
	// Frame build and disparity decision
	// ************************************************************
	wire  toggle_bit = hold_s_r ? 1'b1 : toggle_r;
	wire  [PAYLOAD_W-1:0] payload = in_seed ? seq_word : (i_data ^ seq_word);
	wire  [FRAME_W-2:0]   inv63 = {toggle_bit, payload};
	wire  signed [DISP_W-1:0] plain_disp = word_disp({1'b0, inv63}) + DISP_W'(1);
	wire  signed [DISP_W-1:0] trial = disp_r + plain_disp - DISP_W'(1);
	wire  over = (trial > DISP_W'(DISP_LIMIT)) || (trial < -DISP_W'(DISP_LIMIT));
	wire  [FRAME_W-1:0]   coded = over ? {1'b1, ~inv63}
	                                   : {1'b0, inv63};
	wire  [FRAME_W-1:0]   frame_nxt = in_pat ? ALIGN_WORD : coded;
	wire  signed [DISP_W-1:0] disp_nxt = in_pat ? disp_r : disp_r + word_disp(coded);

	assign o_data_ready    = buf_ready & in_idle;
	assign o_pattern_phase = in_pat;
	assign o_seed_phase    = in_seed;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			phase_r  <= ST_IDLE;
			cnt_r    <= '0;
			toggle_r <= 1'b0;
			disp_r   <= '0;
			lfsr_r   <= LFSR_SEED;
		end else if (i_clk_en) begin
			phase_r <= phase_nxt;
			if (sync_pulse) begin
				cnt_r    <= '0;
				toggle_r <= 1'b0;
				disp_r   <= '0;
				lfsr_r   <= LFSR_SEED;
			end else if (fire) begin
				if (!in_idle) begin
					cnt_r <= cnt_last ? '0 : cnt_r + CNT_W'(1);
				end
				if (lane_step) begin
					toggle_r <= ~toggle_r;
					lfsr_r   <= lfsr_b;
					disp_r   <= disp_nxt;
				end
			end
		end
	end

	// ************************************************************
	// Two-entry output buffer
	// ************************************************************
	// Ready is registered-free of the sink, so a stall costs no word
	logic [FRAME_W-1:0] ent_r [2];
	logic               rd_ptr_r;
	logic               wr_ptr_r;
	logic [1:0]         fill_r;
	wire                pop = o_frame_valid & i_frame_ready;
	// A frame built on the sync cycle belongs to the old sequence: drop it
	wire                push = fire & ~sync_pulse;
	wire                buf_full = (fill_r == 2'h2);
	wire                buf_empty = (fill_r == 2'h0);

	assign buf_ready     = ~buf_full;
	assign o_frame_valid = ~buf_empty;
	assign o_frame       = ent_r[rd_ptr_r];

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ent_r[0] <= '0;
			ent_r[1] <= '0;
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			fill_r   <= 2'd0;
		end else if (i_clk_en) begin
			if (push) begin
				ent_r[wr_ptr_r] <= frame_nxt;
				wr_ptr_r        <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			fill_r <= fill_r + 2'(push) - 2'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== lane_enc_checker.sv
// Port checker for the lane frame encoder
`timescale 1ns/1ps
`default_nettype none
module lane_enc_checker
	import lane_enc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic        i_data_valid,
	input  wire logic        o_data_ready,
	input  wire logic [63:0] o_frame,
	input  wire logic        o_frame_valid,
	input  wire logic        i_frame_ready,
	input  wire logic        o_pattern_phase,
	input  wire logic        o_seed_phase
);
	// ****
	// Wire disparity of popped frames; pattern frames are balanced
	// ****
	logic signed [9:0] disp_r;
	wire  logic        pop = o_frame_valid && i_frame_ready && i_clk_en;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) disp_r <= '0;
		else if (o_pattern_phase) disp_r <= '0;
		else if (pop) disp_r <= disp_r + 10'(2 * $countones(o_frame)) - 10'sd64;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	a_hold_stall: assert property (o_frame_valid && !i_frame_ready |=>
		o_frame_valid && $stable(o_frame)) else $error("Frame lost or changed in stall");
	a_disp_bound: assert property (disp_r <= 64 && disp_r >= -64)
		else $error("Running disparity out of bounds");
	a_phase_excl: assert property (!(o_pattern_phase && o_seed_phase))
		else $error("Both phases active");
	a_busy_refuse: assert property (o_pattern_phase || o_seed_phase |-> !o_data_ready)
		else $error("Data taken during alignment");
	a_fill_answer: assert property (i_data_valid && o_data_ready && i_clk_en &&
		!o_frame_valid |=> o_frame_valid) else $error("No frame after accepted word");
	a_idle_ready: assert property (!o_pattern_phase && !o_seed_phase && !o_frame_valid
		|-> o_data_ready) else $error("Idle and empty but not ready");
	a_seed_follow: assert property ($fell(o_pattern_phase) |-> o_seed_phase)
		else $error("Sequence frames do not follow pattern");
	a_pattern_run: assert property ($rose(o_pattern_phase) |-> o_pattern_phase[*4])
		else $error("Pattern phase too short");
endmodule
bind lane_62b64b_frame_encoder lane_enc_checker chk (.i_sys_clk(i_sys_clk),
	.i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_data_valid(i_data_valid),
	.o_data_ready(o_data_ready), .o_frame(o_frame), .o_frame_valid(o_frame_valid),
	.i_frame_ready(i_frame_ready), .o_pattern_phase(o_pattern_phase),
	.o_seed_phase(o_seed_phase));
`default_nettype wire

// ===== lane_enc_pkg.sv
// Constants and types for the 62b/64b lane frame encoder
package lane_enc_pkg;
	localparam int             FRAME_W        = 64;
	localparam int             PAYLOAD_W      = 62;
	localparam int             LFSR_W         = 31;
	localparam int             TOGGLE_POS     = 62;
	localparam int             INV_POS        = 63;
	localparam int             LFSR_TAP_LO    = 3;
	localparam logic [63:0]    ALIGN_PATTERN  = 64'hACF0_FF00_FFFF_0000;
	localparam logic [30:0]    LFSR_SEED_DEF  = 31'h0000_0001;
	localparam int             ALIGN_FRAMES   = 32;
	localparam int             SEED_FRAMES    = 32;
	localparam int             DISP_LIMIT     = 64;
	localparam int             DISP_W         = 9;
	localparam int             CNT_W          = 6;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_PATTERN = 3'b010,
		ST_SEED    = 3'b100
	} phase_e;
endpackage

// ===== lane_rx_model.sv
// Receiver model: flag undo, toggle watch, seed capture, descramble
`timescale 1ns/1ps
`default_nettype none
module lane_rx_model
	import lane_enc_pkg::*;
#(
	parameter int SEED_N = 4
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_slow,
	input  wire logic        i_hold,
	input  wire logic [63:0] i_frame,
	input  wire logic        i_frame_valid,
	output logic             o_frame_ready,
	output logic [61:0]      o_word,
	output logic             o_wvalid,
	output logic             o_bad
);
	// ****
	// Slow mode stalls half the time to fill the encoder buffer
	// ****
	logic [30:0] s, a, b;
	logic [62:0] f;
	logic        tg, fst = 1'b1;
	int          n = 0;
	logic [3:0]  k = '0;
	assign o_frame_ready = !(i_slow && k[1]);
	function automatic logic [30:0] stp(input logic [30:0] x);
		return {x[30:3] ^ x[27:0], x[2:0] ^ x[30:28] ^ x[27:25]};
	endfunction
	always @(posedge i_sys_clk) begin
		k <= k + 4'h1;
		o_wvalid <= 1'b0;
		o_bad <= 1'b0;
		if (i_frame_valid && o_frame_ready) begin
			f = i_frame[63] ? ~i_frame[62:0] : i_frame[62:0];
			a = stp(s);
			b = stp(a);
			if (i_frame == ALIGN_PATTERN) begin
				n = 0;
				fst = 1'b1;
			end else begin
				// First frame after the pattern has no predecessor to compare
				o_bad <= (!fst && f[62] !== (i_hold | !tg)) ||
					(n > 0 && n < SEED_N && f[61:0] !== {b, a});
				o_word <= f[61:0] ^ {b, a};
				o_wvalid <= (n >= SEED_N);
				s = (n == 0) ? f[61:31] : b;
				tg = f[62];
				fst = 1'b0;
				n = n + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb_lane_62b64b_frame_encoder.sv
// Self-checking bench for the lane frame encoder
`timescale 1ns/1ps
`default_nettype none
module tb_lane_62b64b_frame_encoder;
	import lane_enc_pkg::*;
	// ****
	// Rows: each word must come back unchanged through the receiver
	// ****
	logic        clk = 0, rst = 1, sync = 0, hold = 0, dv = 0, slow = 0;
	logic        dr, fv, fr, pp, sp, bad, wv, seen;
	logic [61:0] d = '0, w, q[$];
	logic [63:0] fo;
	logic [61:0] rows[4] = '{62'h0, '1, 62'h2AAA_AAAA_AAAA_AAAA, 62'h0123_4567_89AB_CDEF};
	localparam int N_SEQ = 4;
	int          n_errors = 0, num_checks = 0, npat = 0, nref = 0, ninv = 0;
	lane_62b64b_frame_encoder #(.ALIGN_COUNT(N_SEQ), .SEED_COUNT(N_SEQ)) uut (.i_sys_clk(clk),
		.i_sys_rst(rst), .i_clk_en(1'b1), .i_sync(sync), .i_toggle_hold(hold), .i_data(d),
		.i_data_valid(dv), .o_data_ready(dr), .o_frame(fo), .o_frame_valid(fv),
		.i_frame_ready(fr), .o_pattern_phase(pp), .o_seed_phase(sp));
	lane_rx_model #(.SEED_N(N_SEQ)) rx (.i_sys_clk(clk), .i_slow(slow), .i_hold(hold),
		.i_frame(fo), .i_frame_valid(fv), .o_frame_ready(fr), .o_word(w), .o_wvalid(wv),
		.o_bad(bad));
	initial forever #4 clk = ~clk;
	task automatic fail(input string m);
		n_errors++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic check(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) fail(m);
	endtask
	task automatic conclude;
		$display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (fv && fr && fo === ALIGN_PATTERN) npat++;
		if (fv === 1'b1 && fr === 1'b1 && fo !== ALIGN_PATTERN && fo[INV_POS] === 1'b1) ninv++;
		if (bad === 1'b1) fail("bad header or sequence frame");
		if (wv === 1'b1) check(q.size() > 0 && w === q.pop_front(), "word mismatch");
	end
	task automatic send(input logic [61:0] x);
		int   t;
		logic ok;
		t = 0;
		ok = 1'b0;
		#1 d = x;
		dv = 1'b1;
		do begin
			@(negedge clk);
			ok = (dr === 1'b1);
			@(posedge clk);
			t++;
		end while (!ok && t < 50);
		if (t > 1) nref++;
		if (!ok) begin
			fail("word never accepted");
			conclude();
		end
		q.push_back(x);
	endtask
	task automatic resync;
		int t;
		#1 sync = 1'b1;
		npat = 0;
		seen = 1'b0;
		for (t = 0; t < 300 && !(seen && pp === 1'b0 && sp === 1'b0 && fv === 1'b0); t++) begin
			@(posedge clk);
			#1;
			seen |= (sp === 1'b1);
		end
		sync = 1'b0;
		@(posedge clk);
		check(t < 300 && npat == N_SEQ && seen, "alignment sequence wrong");
		if (t >= 300) conclude();
	endtask
	task automatic drain;
		int t;
		#1 dv = 1'b0;
		for (t = 0; t < 300 && q.size() > 0; t++) @(posedge clk);
		check(q.size() == 0, "words lost");
		if (q.size() != 0) conclude();
		@(posedge clk);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		check(dr === 1'b1 && fv === 1'b0 && pp === 1'b0 && sp === 1'b0, "reset state");
		@(posedge clk);
		resync();
		foreach (rows[i]) send(rows[i]);
		drain();
		$display("Row test done");
		#1 slow = 1'b1;
		@(posedge clk);
		repeat (3) foreach (rows[i]) send(~rows[i]);
		drain();
		check(nref > 0, "full buffer never refused");
		check(ninv > 0, "no inverted frame seen");
		$display("Stall test done");
		#1 hold = 1'b1;
		@(posedge clk);
		resync();
		foreach (rows[i]) send(rows[i]);
		drain();
		$display("Hold test done");
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		check(dr === 1'b1 && fv === 1'b0 && pp === 1'b0 && sp === 1'b0, "mid-run reset state");
		@(posedge clk);
		resync();
		foreach (rows[i]) send(rows[i]);
		drain();
		$display("Reset test done");
		conclude();
	end
endmodule
`default_nettype wire
